// *** rtl/llpc_pkg.sv ***
// Constants, register map and helper functions for the line-locked pixel clock generator
package llpc_pkg;

  localparam int MCLK_HZ = 125_000_000;

  // Numerically controlled pixel oscillator: 24 fraction bits per pixel
  localparam int ACC_W  = 32;
  localparam int FRAC_W = 24;
  localparam int INC_W  = 26;
  localparam int ERR_W  = 14;
  localparam int MATH_W = 28;
  localparam int LOOP_SHIFT = 10;
  localparam logic [ERR_W-1:0] LOCK_TOL = 14'h0002;

  // Reference line-rate window
  localparam int HS_RATE_MIN_KHZ  = 15;
  localparam int HS_RATE_MAX_KHZ  = 110;
  localparam int IVL_W            = 14;
  localparam int LINE_MIN_CYC     = (MCLK_HZ + HS_RATE_MAX_KHZ * 1000 - 1)
                                    / (HS_RATE_MAX_KHZ * 1000);
  localparam int LINE_MAX_CYC_DEF = MCLK_HZ / (HS_RATE_MIN_KHZ * 1000);

  // Divisor range that software must respect
  localparam logic [11:0] DIV_MIN = 12'h0DD;
  localparam logic [11:0] DIV_MAX = 12'hFFF;

  // Register indices; byte address is four times the index
  localparam int          ADDR_W     = 6;
  localparam logic [3:0]  IDX_DIV_HI = 4'h1;
  localparam logic [3:0]  IDX_DIV_LO = 4'h2;
  localparam logic [3:0]  IDX_LOOP   = 4'h3;
  localparam logic [3:0]  IDX_OUTCTL = 4'h4;
  localparam logic [3:0]  IDX_PHASE  = 4'h5;
  localparam logic [3:0]  IDX_INCTL  = 4'h6;
  localparam logic [3:0]  IDX_STATUS = 4'h7;
  localparam logic [3:0]  IDX_FREQ   = 4'h8;

  // Field positions
  localparam int DIV_LO_POS   = 4;
  localparam int BAND_POS     = 6;
  localparam int CP_POS       = 3;
  localparam int OUTPOL_BIT   = 4;
  localparam int HSPOL_BIT    = 0;
  localparam int COASTPOL_BIT = 1;
  localparam int EXTSEL_BIT   = 2;
  localparam int ST_LOCK_BIT  = 0;
  localparam int ST_COAST_BIT = 1;
  localparam int ST_EXT_BIT   = 2;
  localparam int ST_LOST_BIT  = 3;

  // Reset values
  localparam logic [11:0] DIV_RST      = 12'h31F;
  localparam logic [1:0]  BAND_RST     = 2'h0;
  localparam logic [2:0]  CP_RST       = 3'h3;
  localparam logic [4:0]  PHASE_RST    = 5'h00;
  localparam logic        OUTPOL_RST   = 1'h1;
  localparam logic        HSPOL_RST    = 1'h1;
  localparam logic        COASTPOL_RST = 1'h1;
  localparam logic        EXTSEL_RST   = 1'h0;
  localparam int          INC_RST_MHZ  = 25;

  function automatic logic [INC_W-1:0] freq_inc(input int mhz);
    longint num;
    num = longint'(mhz) * 64'd1000000 * (64'd1 << FRAC_W);
    return INC_W'(num / longint'(MCLK_HZ));
  endfunction : freq_inc

  function automatic logic [INC_W-1:0] band_lo(input logic [1:0] code);
    case (code)
      2'h0:    return freq_inc(12);
      2'h1:    return freq_inc(37);
      2'h2:    return freq_inc(74);
      default: return freq_inc(140);
    endcase
  endfunction : band_lo

  function automatic logic [INC_W-1:0] band_hi(input logic [1:0] code);
    case (code)
      2'h0:    return freq_inc(37);
      2'h1:    return freq_inc(74);
      2'h2:    return freq_inc(140);
      default: return freq_inc(170);
    endcase
  endfunction : band_hi

  // Drive current in microamperes
  function automatic logic [10:0] cp_ua(input logic [2:0] code);
    case (code)
      3'h0:    return 11'h032;
      3'h1:    return 11'h064;
      3'h2:    return 11'h096;
      3'h3:    return 11'h0FA;
      3'h4:    return 11'h15E;
      3'h5:    return 11'h1F4;
      3'h6:    return 11'h2EE;
      default: return 11'h5DC;
    endcase
  endfunction : cp_ua

endpackage : llpc_pkg

// *** rtl/llpc_pin_sync.sv ***
// Two-flop pin synchroniser with polarity select and active-edge pulse
`timescale 1ns/100ps
`default_nettype none
module llpc_pin_sync (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic pin_in,
  input  wire logic active_high,
  output logic      level,
  output logic      rise
);

  logic s1_reg;
  logic s2_reg;
  logic lvl_reg;
  logic rise_reg;
  wire  lvl_next = active_high ? s2_reg : ~s2_reg;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_reg   <= 1'h0;
      s2_reg   <= 1'h0;
      lvl_reg  <= 1'h0;
      rise_reg <= 1'h0;
    end else begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      lvl_reg  <= lvl_next;
      rise_reg <= lvl_next & ~lvl_reg;
    end
  end

  assign level = lvl_reg;
  assign rise  = rise_reg;

endmodule : llpc_pin_sync
`default_nettype wire

// *** rtl/llpc_line_clock_gen.sv ***
// Line-locked pixel clock generator: register slave, oscillator model, loop and phase shift
//
// Functional notes
// R1 - Divisor is upper bits from index 0x01 and lower bits from index 0x02.
// R2 - Divided oscillator is compared with line sync; error steers frequency.
// R3 - Software programs divisor only within 221 to 4095.
// R4 - Effective division ratio is the divisor plus one.
// R5 - Line sync accepted from 15 to 110 kHz; pixel clock multiplies it.
// R6 - Two-bit band code limits oscillator to one of four frequency bands.
// R7 - Three-bit drive code selects 50 to 1500 microampere loop current.
// R8 - Five-bit phase shifts sampling clock in 32 steps across one pixel.
// R9 - Line sync output carries the same phase shift as sampling clock.
// R10 - Phase shift also applies when pixel clock comes from outside.
// R11 - While coasting, frequency holds and line sync is ignored.
// R12 - Separate polarity bits set active levels of sync and coast inputs.
// R13 - Software sets input polarity bits to match real signal polarity.
// R14 - Software picks band and drive codes per display format.
// R15 - Bit 4 of index 0x04 sets output line sync polarity.
// R16 - Feedback counter counts pixels to divisor, wraps, pulses once a line.
`timescale 1ns/100ps
`default_nettype none
module llpc_line_clock_gen #(
  parameter int LINE_MAX_CYC = llpc_pkg::LINE_MAX_CYC_DEF
) (
  input  wire logic                         mclk,
  input  wire logic                         resetn,
  input  wire logic [llpc_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         line_sync_in,
  input  wire logic                         coast_in,
  input  wire logic                         ext_pixel_clk_in,
  output logic                              pixel_tick,
  output logic                              sample_tick,
  output logic                              sample_clk_out,
  output logic                              line_ref_pulse,
  output logic                              regenerated_line_sync_out,
  output logic      [1:0]                   oscillator_band_code,
  output logic      [10:0]                  drive_current_ua,
  output logic                              locked
);

  // Register file
  logic [7:0]  div_hi_reg;
  logic [3:0]  div_lo_reg;
  logic [1:0]  band_reg;
  logic [2:0]  cp_reg;
  logic        outpol_reg;
  logic [4:0]  phase_reg;
  logic        hspol_reg;
  logic        coastpol_reg;
  logic        extsel_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;

  // Loop state
  logic [llpc_pkg::ACC_W-1:0]  acc_reg;
  logic [llpc_pkg::INC_W-1:0]  inc_reg;
  logic [11:0]                 fb_cnt_reg;
  logic [llpc_pkg::IVL_W-1:0]  ivl_reg;
  logic                        lock_reg;
  logic                        lost_reg;

  // External clock phase delay
  logic [11:0] per_cnt_reg;
  logic [11:0] per_reg;
  logic [11:0] dly_cnt_reg;
  logic        arm_reg;

  // Outputs from flops
  logic        pix_tick_reg;
  logic        samp_reg;
  logic        samp_clk_reg;
  logic        line_ref_reg;
  logic        sync_out_reg;

  // Synchronised pins
  logic hs_level;
  logic hs_rise;
  logic coast_level;
  logic ext_rise;

  llpc_pin_sync u_hs_sync (
    .mclk        (mclk),
    .resetn      (resetn),
    .pin_in      (line_sync_in),
    .active_high (hspol_reg),
    .level       (hs_level),
    .rise        (hs_rise)
  ); // R12

  llpc_pin_sync u_coast_sync (
    .mclk        (mclk),
    .resetn      (resetn),
    .pin_in      (coast_in),
    .active_high (coastpol_reg),
    .level       (coast_level),
    .rise        ()
  ); // R12

  // External clock is only edge-detected; its level is of no use here
  llpc_pin_sync u_ext_sync (
    .mclk        (mclk),
    .resetn      (resetn),
    .pin_in      (ext_pixel_clk_in),
    .active_high (1'h1),
    .level       (),
    .rise        (ext_rise)
  );

  // Bus decode: one wait state on every access
  wire [3:0] idx      = avs_address[llpc_pkg::ADDR_W-1:2];
  wire       req      = avs_read | avs_write;
  wire       wr_fire  = avs_write & ack_reg & avs_byteenable[0];
  wire       rd_cap   = avs_read & ~ack_reg;
  wire       sel_dhi  = idx == llpc_pkg::IDX_DIV_HI;
  wire       sel_dlo  = idx == llpc_pkg::IDX_DIV_LO;
  wire       sel_loop = idx == llpc_pkg::IDX_LOOP;
  wire       sel_out  = idx == llpc_pkg::IDX_OUTCTL;
  wire       sel_ph   = idx == llpc_pkg::IDX_PHASE;
  wire       sel_in   = idx == llpc_pkg::IDX_INCTL;
  wire       sel_st   = idx == llpc_pkg::IDX_STATUS;
  wire       sel_fq   = idx == llpc_pkg::IDX_FREQ;
  wire [7:0] wd       = avs_writedata[7:0];

  // Unmapped indices read as zero; writes to them are dropped
  wire [31:0] rd_mux =
      sel_dhi  ? {24'h000000, div_hi_reg} :
      sel_dlo  ? {24'h000000, div_lo_reg, 4'h0} :
      sel_loop ? {24'h000000, band_reg, cp_reg, 3'h0} :
      sel_out  ? {27'h0000000, outpol_reg, 4'h0} :
      sel_ph   ? {27'h0000000, phase_reg} :
      sel_in   ? {29'h00000000, extsel_reg, coastpol_reg, hspol_reg} :
      sel_st   ? {28'h0000000, lost_reg, extsel_reg, coast_level, lock_reg} :
      sel_fq   ? {6'h00, inc_reg} :
                 32'h00000000;

  // Read data are captured in the wait cycle and stand while waitrequest is low
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_reg   <= 1'h0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (rd_cap) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_hi_reg   <= llpc_pkg::DIV_RST[11:4];
      div_lo_reg   <= llpc_pkg::DIV_RST[3:0];
      band_reg     <= llpc_pkg::BAND_RST;
      cp_reg       <= llpc_pkg::CP_RST;
      outpol_reg   <= llpc_pkg::OUTPOL_RST;
      phase_reg    <= llpc_pkg::PHASE_RST;
      hspol_reg    <= llpc_pkg::HSPOL_RST;
      coastpol_reg <= llpc_pkg::COASTPOL_RST;
      extsel_reg   <= llpc_pkg::EXTSEL_RST;
    end else if (wr_fire) begin
      if (sel_dhi) begin
        div_hi_reg <= wd; // R1
      end
      if (sel_dlo) begin
        div_lo_reg <= wd[llpc_pkg::DIV_LO_POS +: 4]; // R1
      end
      if (sel_loop) begin
        band_reg <= wd[llpc_pkg::BAND_POS +: 2]; // R6
        cp_reg   <= wd[llpc_pkg::CP_POS +: 3]; // R7
      end
      if (sel_out) begin
        outpol_reg <= wd[llpc_pkg::OUTPOL_BIT]; // R15
      end
      if (sel_ph) begin
        phase_reg <= wd[4:0]; // R8
      end
      if (sel_in) begin
        hspol_reg    <= wd[llpc_pkg::HSPOL_BIT]; // R12
        coastpol_reg <= wd[llpc_pkg::COASTPOL_BIT]; // R12
        extsel_reg   <= wd[llpc_pkg::EXTSEL_BIT];
      end
    end
  end

  // Feedback ratio and oscillator model
  wire [11:0] divisor = {div_hi_reg, div_lo_reg}; // R1
  wire [12:0] ratio   = {1'h0, divisor} + 13'h0001; // R4
  wire [12:0] half    = {1'h0, ratio[12:1]};

  wire [llpc_pkg::ACC_W-1:0] acc_next = acc_reg + {6'h00, inc_reg};
  // Increment never reaches two full pixels, so a 2-bit difference is exact
  wire [1:0]  nco_ticks = acc_next[25:24] - acc_reg[25:24];
  // External edges replace the oscillator as the pixel source
  wire [1:0]  ticks     = extsel_reg ? {1'h0, ext_rise} : nco_ticks;

  wire [12:0] fb_sum  = {1'h0, fb_cnt_reg} + {11'h000, ticks};
  wire        fb_wrap = fb_sum >= ratio; // R16
  wire [12:0] fb_rem  = fb_sum - ratio;
  // A ratio cut to half the running count or below restarts the count, so the
  // feedback pulse cannot repeat on the following cycles
  wire [11:0] fb_wrapped = (fb_rem >= ratio) ? 12'h000 : fb_rem[11:0]; // R16

  // Reference qualification: rate window and coast
  wire        ivl_short = ivl_reg < llpc_pkg::IVL_W'(llpc_pkg::LINE_MIN_CYC); // R5
  wire        ivl_long  = ivl_reg > llpc_pkg::IVL_W'(LINE_MAX_CYC); // R5
  // Edges too close together are taken as noise and never steer the loop
  wire        ref_edge  = hs_rise & ~coast_level & ~ivl_short & ~extsel_reg; // R11

  // Phase error in pixels: positive means the oscillator ran fast
  wire signed [llpc_pkg::ERR_W-1:0] err =
      ({1'h0, fb_cnt_reg} <= half) ? $signed({2'h0, fb_cnt_reg})
                                   : $signed({2'h0, fb_cnt_reg}) - $signed({1'h0, ratio}); // R2
  wire [llpc_pkg::ERR_W-1:0] err_abs = err[llpc_pkg::ERR_W-1] ? 14'(-err) : 14'(err);

  wire [10:0] cur_ua = llpc_pkg::cp_ua(cp_reg); // R7
  // Loop gain tracks the drive current; 50 uA is one unit
  wire [5:0]  gain   = 6'(cur_ua / 11'h032);
  wire signed [llpc_pkg::MATH_W-1:0] step =
      llpc_pkg::MATH_W'(err * $signed({1'h0, gain})) <<< llpc_pkg::LOOP_SHIFT; // R7
  wire signed [llpc_pkg::MATH_W-1:0] inc_try = $signed({2'h0, inc_reg}) - step; // R2

  wire [llpc_pkg::INC_W-1:0] lo_lim = llpc_pkg::band_lo(band_reg); // R6
  wire [llpc_pkg::INC_W-1:0] hi_lim = llpc_pkg::band_hi(band_reg); // R6
  wire under = inc_try < $signed({2'h0, lo_lim});
  wire over  = inc_try > $signed({2'h0, hi_lim});
  wire [llpc_pkg::INC_W-1:0] inc_clamped =
      under ? lo_lim : over ? hi_lim : llpc_pkg::INC_W'(inc_try); // R6

  // A band change pulls the held frequency into the new band at once
  wire inc_reg_in_band = (inc_reg >= lo_lim) & (inc_reg <= hi_lim); // R6

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      acc_reg    <= 32'h00000000;
      inc_reg    <= llpc_pkg::freq_inc(llpc_pkg::INC_RST_MHZ);
      fb_cnt_reg <= 12'h000;
      ivl_reg    <= 14'h0000;
      lock_reg   <= 1'h0;
      lost_reg   <= 1'h0;
    end else begin
      acc_reg <= acc_next;
      // Interval counter saturates so a dead reference reads as too slow
      if (hs_rise) begin
        ivl_reg <= 14'h0000;
      end else if (ivl_reg != 14'h3FFF) begin
        ivl_reg <= ivl_reg + 14'h0001;
      end
      if (ref_edge) begin
        // Realign the divider to the reference so the next error is pure frequency
        fb_cnt_reg <= 12'(ticks); // R2
        inc_reg    <= inc_clamped; // R2
        lock_reg   <= err_abs <= llpc_pkg::LOCK_TOL;
        lost_reg   <= 1'h0;
      end else begin
        fb_cnt_reg <= fb_wrap ? fb_wrapped : fb_sum[11:0]; // R16
        if (!inc_reg_in_band) begin
          inc_reg <= inc_clamped; // R6
        end
        if (ivl_long & ~coast_level) begin
          lock_reg <= 1'h0; // R5
          lost_reg <= 1'h1;
        end
      end
    end
  end

  // Sampling phase, internal clock: offset the accumulator by phase/32 pixel
  wire [llpc_pkg::ACC_W-1:0] ph_off  = {8'h00, phase_reg, 19'h00000}; // R8
  wire [llpc_pkg::ACC_W-1:0] sh_now  = acc_reg + ph_off;
  wire [llpc_pkg::ACC_W-1:0] sh_next = acc_next + ph_off;
  wire                       int_samp = sh_next[25:24] != sh_now[25:24]; // R8

  // Sampling phase, external clock: delay each edge by phase/32 of its period
  wire [16:0] dly_prod   = {5'h00, per_reg} * {12'h000, phase_reg};
  wire [11:0] dly_target = dly_prod[16:5]; // R10
  wire        ext_samp   = arm_reg & (dly_cnt_reg == dly_target); // R10
  // The loop is frozen in external mode, yet phase still shifts each edge
  wire        samp       = extsel_reg ? ext_samp : int_samp;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      per_cnt_reg <= 12'h000;
      per_reg     <= 12'h000;
      dly_cnt_reg <= 12'h000;
      arm_reg     <= 1'h0;
    end else begin
      if (ext_rise) begin
        per_cnt_reg <= 12'h001;
        per_reg     <= per_cnt_reg; // R10
        dly_cnt_reg <= 12'h000;
        arm_reg     <= 1'h1;
      end else begin
        if (per_cnt_reg != 12'hFFF) begin
          per_cnt_reg <= per_cnt_reg + 12'h001;
        end
        dly_cnt_reg <= dly_cnt_reg + 12'h001;
        if (ext_samp) begin
          arm_reg <= 1'h0;
        end
      end
    end
  end

  // Output flops
  // Strobes are registered so consumers see clean one-cycle pulses
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pix_tick_reg <= 1'h0;
      samp_reg     <= 1'h0;
      samp_clk_reg <= 1'h0;
      line_ref_reg <= 1'h0;
      sync_out_reg <= ~llpc_pkg::OUTPOL_RST;
    end else begin
      pix_tick_reg <= ticks != 2'h0;
      samp_reg     <= samp; // R8
      line_ref_reg <= fb_wrap & ~ref_edge; // R16
      if (samp) begin
        samp_clk_reg <= ~samp_clk_reg;
        // Sync is retimed on the phased sampling edge, so it carries the same shift
        sync_out_reg <= ~(hs_level ^ outpol_reg); // R9 R15
      end
    end
  end

  assign avs_readdata              = rdata_reg;
  assign avs_waitrequest           = req & ~ack_reg;
  assign pixel_tick                = pix_tick_reg;
  assign sample_tick               = samp_reg;
  assign sample_clk_out            = samp_clk_reg;
  assign line_ref_pulse            = line_ref_reg;
  assign regenerated_line_sync_out = sync_out_reg;
  assign oscillator_band_code      = band_reg; // R6
  assign drive_current_ua          = cur_ua; // R7
  assign locked                    = lock_reg;

endmodule : llpc_line_clock_gen
`default_nettype wire

// *** tb/llpc_checker.sv ***
// Port-level assertions for the line-locked pixel clock generator
`timescale 1ns/100ps
`default_nettype none
module llpc_checker #(
  parameter int LINE_MAX_CYC = 8333
) (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        line_sync_in,
  input wire logic        coast_in,
  input wire logic        ext_pixel_clk_in,
  input wire logic        pixel_tick,
  input wire logic        sample_tick,
  input wire logic        sample_clk_out,
  input wire logic        line_ref_pulse,
  input wire logic        regenerated_line_sync_out,
  input wire logic [1:0]  oscillator_band_code,
  input wire logic [10:0] drive_current_ua,
  input wire logic        locked
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic req = avs_read | avs_write;

  chk_wait_first: assert property (
    req && !$past(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus request not answered after exactly one wait cycle");
  chk_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  chk_read_width: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:26] == 6'h00)
    else $error("read data wider than any register");
  chk_drive_table: assert property (drive_current_ua inside {11'h032, 11'h064,
    11'h096, 11'h0FA, 11'h15E, 11'h1F4, 11'h2EE, 11'h5DC})
    else $error("drive current outside its code table");
  chk_band_by_write: assert property (
    $changed(oscillator_band_code) |-> $past(avs_write && !avs_waitrequest))
    else $error("band code moved without a register write");
  chk_sync_on_tick: assert property ($changed(regenerated_line_sync_out)
    |-> sample_tick || $past(avs_write) || $past(avs_write, 2))
    else $error("sync output moved off the sampling instant");
  chk_clk_on_tick: assert property (
    $changed(sample_clk_out) |-> sample_tick || $past(sample_tick))
    else $error("sampling clock toggled without a sampling tick");
  chk_ref_single: assert property (line_ref_pulse |=> !line_ref_pulse [*8])
    else $error("feedback pulses closer than any legal ratio");
  chk_lock_reset: assert property ($rose(resetn) |-> !locked)
    else $error("locked set straight out of reset");
endmodule : llpc_checker
`default_nettype wire

// *** tb/llpc_video_source.sv ***
// Graphics source model: line sync pulses and an optional external pixel clock
`timescale 1ns/100ps
`default_nettype none
module llpc_video_source (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic ext_run,
  output var logic  line_sync_in = 1'h0,
  output var logic  ext_pixel_clk_in = 1'h0
);
  // 1600 mclk per line is 78 kHz, inside the accepted line-rate window
  int cnt = 0;
  always @(posedge mclk) begin
    cnt <= (cnt >= 1599) ? 0 : cnt + 1;
    line_sync_in <= run && (cnt < 96);
    // External clock stands still while unused; 15.6 MHz keeps under the sampling limit
    ext_pixel_clk_in <= ext_run & cnt[2];
  end
endmodule : llpc_video_source
`default_nettype wire

// *** tb/llpc_line_clock_gen_tb.sv ***
// Self-checking bench for the line-locked pixel clock generator
`timescale 1ns/100ps
`default_nettype none
module llpc_line_clock_gen_tb;
  localparam int LMAX = 2000;
  logic        mclk, resetn, rd, wr, coast, run, ext_run;
  logic [5:0]  addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata, f0, avs_readdata;
  logic        avs_waitrequest, pixel_tick, sample_tick, sample_clk_out, line_ref_pulse;
  logic        sync_out, locked, line_sync_in, ext_clk;
  logic [1:0]  band;
  logic [10:0] drive_current_ua;
  int          bad_count = 0;
  int          n_checks = 0;
  logic [10:0] ua_tab [8] = '{11'h032, 11'h064, 11'h096, 11'h0FA,
                              11'h15E, 11'h1F4, 11'h2EE, 11'h5DC};

  llpc_line_clock_gen #(.LINE_MAX_CYC(LMAX)) dut (
    .mclk(mclk), .resetn(resetn), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .line_sync_in(line_sync_in), .coast_in(coast),
    .ext_pixel_clk_in(ext_clk), .pixel_tick(pixel_tick), .sample_tick(sample_tick),
    .sample_clk_out(sample_clk_out), .line_ref_pulse(line_ref_pulse),
    .regenerated_line_sync_out(sync_out), .oscillator_band_code(band),
    .drive_current_ua(drive_current_ua), .locked(locked));
  llpc_video_source src (.mclk(mclk), .run(run), .ext_run(ext_run),
    .line_sync_in(line_sync_in), .ext_pixel_clk_in(ext_clk));

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdata = avs_readdata;
    if (n >= 20) check("waitrequest", 32'h0, 32'h1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rd_chk(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 8'h00);
    check(nm, exp, rdata);
  endtask : rd_chk

  task automatic t_reset;
    rd_chk("div_hi", 4'h1, 32'h31);
    rd_chk("div_lo", 4'h2, 32'hF0);
    rd_chk("loop", 4'h3, 32'h18);
    rd_chk("outctl", 4'h4, 32'h10);
    rd_chk("phase", 4'h5, 32'h00);
    rd_chk("inctl", 4'h6, 32'h03);
    rd_chk("unmapped", 4'hF, 32'h00);
    check("drive_ua", 32'hFA, {21'h0, drive_current_ua});
  endtask : t_reset

  task automatic t_regs;
    bus(1'b1, 4'h1, 8'h0D);
    bus(1'b1, 4'h2, 8'hD0);
    rd_chk("div_min_hi", 4'h1, 32'h0D);
    rd_chk("div_min_lo", 4'h2, 32'hD0);
    bus(1'b1, 4'h1, 8'hFF);
    bus(1'b1, 4'h2, 8'hFF);
    rd_chk("div_max_lo", 4'h2, 32'hF0);
    be <= 4'h0;
    bus(1'b1, 4'h5, 8'h1F);
    be <= 4'hF;
    rd_chk("masked_write", 4'h5, 32'h00);
    bus(1'b1, 4'hE, 8'hA5);
    rd_chk("unmapped_write", 4'hE, 32'h00);
    bus(1'b1, 4'h1, 8'h18);
    bus(1'b1, 4'h2, 8'hF0);
  endtask : t_regs

  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h3, {i[1:0], i[2:0], 3'h0});
      @(posedge mclk);
      check("drive_code", {21'h0, ua_tab[i]}, {21'h0, drive_current_ua});
      check("band_code", {30'h0, i[1:0]}, {30'h0, band});
    end
    bus(1'b1, 4'h3, 8'h18);
  endtask : t_codes

  // Divisor 399 gives ratio 400; during coast no realign disturbs the divider
  task automatic t_lock_coast;
    int n, cnt;
    run <= 1'b1;
    n = 0;
    while (locked !== 1'b1 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    check("locked", 32'h1, {31'h0, locked});
    coast <= 1'b1;
    repeat (8) @(posedge mclk);
    bus(1'b0, 4'h8, 8'h00);
    f0 = rdata;
    n = 0;
    while (line_ref_pulse !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    cnt = 0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (pixel_tick === 1'b1) cnt++;
    end while (line_ref_pulse !== 1'b1 && n < 3000);
    check("pixels_per_line", 32'h190, cnt);
    run <= 1'b0;
    repeat (2 * LMAX) @(posedge mclk);
    check("coast_locked", 32'h1, {31'h0, locked});
    rd_chk("coast_freq", 4'h8, f0);
    bus(1'b0, 4'h7, 8'h00);
    check("coast_status", 32'h1, {31'h0, rdata[1]});
  endtask : t_lock_coast

  task automatic t_lost_outpol;
    bus(1'b1, 4'h6, 8'h01);
    repeat (LMAX + 200) @(posedge mclk);
    check("lost_locked", 32'h0, {31'h0, locked});
    bus(1'b0, 4'h7, 8'h00);
    check("lost_status", 32'h1, {31'h0, rdata[3]});
    bus(1'b1, 4'h4, 8'h00);
    repeat (50) @(posedge mclk);
    check("sync_idle_low_pol", 32'h1, {31'h0, sync_out});
    bus(1'b1, 4'h4, 8'h10);
    repeat (50) @(posedge mclk);
    check("sync_idle_high_pol", 32'h0, {31'h0, sync_out});
  endtask : t_lost_outpol

  task automatic sample_delay(input logic [7:0] ph, output int d);
    int n;
    logic sc;
    bus(1'b1, 4'h5, ph);
    repeat (40) @(posedge mclk);
    n = 0;
    while (pixel_tick !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    d = 0;
    sc = sample_clk_out;
    while (sample_tick !== 1'b1 && d < 100) begin
      @(posedge mclk);
      d++;
    end
    check("sample_clk_toggle", {31'h0, ~sc}, {31'h0, sample_clk_out});
  endtask : sample_delay

  // External clock of 8 mclk per pixel: half a pixel of phase is 4 mclk
  task automatic t_ext_phase;
    int d0, d16;
    ext_run <= 1'b1;
    bus(1'b1, 4'h6, 8'h05);
    bus(1'b0, 4'h7, 8'h00);
    check("ext_status", 32'h1, {31'h0, rdata[2]});
    sample_delay(8'h00, d0);
    sample_delay(8'h10, d16);
    check("phase_delay", 32'h4, d16 - d0);
  endtask : t_ext_phase

  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    #560000;
    bad_count++;
    finish_test();
  end

  initial begin
    {resetn, rd, wr, coast, run, ext_run} = 6'h00;
    addr = 6'h00;
    wdata = 32'h0;
    be = 4'hF;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_codes();
    t_lock_coast();
    t_lost_outpol();
    t_ext_phase();
    finish_test();
  end
endmodule : llpc_line_clock_gen_tb

bind llpc_line_clock_gen llpc_checker #(.LINE_MAX_CYC(LINE_MAX_CYC)) u_chk (
  .mclk(mclk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .line_sync_in(line_sync_in), .coast_in(coast_in), .ext_pixel_clk_in(ext_pixel_clk_in),
  .pixel_tick(pixel_tick), .sample_tick(sample_tick), .sample_clk_out(sample_clk_out),
  .line_ref_pulse(line_ref_pulse), .regenerated_line_sync_out(regenerated_line_sync_out),
  .oscillator_band_code(oscillator_band_code), .drive_current_ua(drive_current_ua),
  .locked(locked));
`default_nettype wire
